// ---- pkg/tct_pkg.sv ----
package tct_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_MODE0 = 12'h004;
  localparam logic [11:0] OFS_MODE1 = 12'h008;
  localparam logic [11:0] OFS_MODE2 = 12'h00C;
  localparam logic [11:0] OFS_CNT0 = 12'h010;
  localparam logic [11:0] OFS_CNT1 = 12'h014;
  localparam logic [11:0] OFS_CNT2 = 12'h018;
  localparam logic [11:0] OFS_STAT = 12'h01C;

  // Control register fields
  localparam int CTRL_PACER_SEL_BIT = 0;
  localparam int CTRL_CASCADE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Timing: 1 MHz time base from a 40 MHz core clock
  localparam int CORE_CLK_MHZ = 40;
  localparam int TBASE_MHZ = 1;
  localparam int TBASE_DIV = CORE_CLK_MHZ / TBASE_MHZ;
  localparam logic [5:0] TBASE_LAST = 6'(TBASE_DIV - 1);

  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // Counting modes
  typedef enum logic [2:0] {
    M_TC_PULSE = 3'b000,
    M_ONE_SHOT = 3'b001,
    M_RATE_GEN = 3'b010,
    M_SQUARE = 3'b011,
    M_SW_STROBE = 3'b100,
    M_HW_STROBE = 3'b101
  } cnt_mode_t;

  // Per-counter state
  typedef struct packed {
    cnt_mode_t mode;
    logic [15:0] init;   // Last written count
    logic [15:0] cnt;    // Running count
    logic pend;          // Load pending on next counter clock
    logic arm;           // Count written, can be triggered
    logic run;           // Counting active
    logic out;           // Output level
    logic gate_d;        // Previous gate level
    logic trig;          // Latched rising gate edge
    logic sq_low;        // Square wave low half
  } ctr_t;

  // Per-counter pin group
  typedef struct packed {
    logic clk_en;
    logic gate;
  } ctr_in_t;

endpackage

// ---- rtl/triple_counter_timer_block.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - General counter always free; others pace
// RULE_02 - Reset: pacer on bus clock/2; pacer: 1 MHz
// RULE_03 - External clocks on general, cascade only; gates, outputs
// RULE_04 - Mode 0: low on mode, load, high at zero
// RULE_05 - Mode 0 output high n+1 clocks after write
// RULE_06 - Mode 0 gate halts counting; load regardless
// RULE_07 - Mode 1 retriggerable n-clock low one-shot
// RULE_08 - Mode 1 reuses count; gate, writes no effect
// RULE_09 - Mode 2 low one clock at one, reload
// RULE_10 - Mode 2 low gate stops, forces high
// RULE_11 - Mode 2 writes no effect; count one illegal
// RULE_12 - Mode 3 square wave, odd split high longer
// RULE_13 - Mode 3 low gate stops, forces high
// RULE_14 - Mode 4 load, count, low pulse at zero
// RULE_15 - Mode 5 gate edge triggers strobe sequence
// RULE_16 - Mode 5 gate, writes ignored once triggered; the code still reloads on a gate edge
// RULE_17 - Outside leaves cascade pins alone when pacing
// RULE_18 - Cascade: pacer zero decrements upper, both start
// RULE_19 - Normal pacing: pacer terminal count starts conversion
// RULE_20 - Sixteen-bit counts, zero means 65536
// RULE_21 - Mode before count; new mode stops counting
module triple_counter_timer_block
  import tct_pkg::*;
(
  input wire logic core_clk, // 40 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic general_counter_clock_pin, // External clock 0
  input wire logic cascade_counter_clock_pin, // External clock 1
  input wire logic general_counter_gate_pin, // Gate 0
  input wire logic cascade_counter_gate_pin, // Gate 1
  input wire logic pacer_counter_gate_pin, // Gate 2
  output logic general_counter_output_pin, // Output 0
  output logic cascade_counter_output_pin, // Output 1
  output logic pacer_counter_output_pin, // Output 2
  output logic conv_start // Conversion start pulse
);

  typedef struct packed {
    ctr_t [2:0] ctr;
    logic [1:0] ctrl;
    logic [5:0] tb_div;
    logic half_div;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [1:0] eclk_d;
    logic conv;
    logic [31:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic tb_tick;
  logic pace_sel;
  logic [2:0] cen;
  logic [2:0] gate;
  logic [2:0] tc;

  // Loads a written value: zero means full range
  function automatic logic [15:0] load_val(input logic [15:0] v);
    return v; // Zero wraps to 65535 on the first decrement, giving 65536 counts [RULE_20]
  endfunction

  // Advances one counter on its clock enable
  function automatic ctr_t step(input ctr_t c, input logic ce, input logic g,
                                output logic tcp);
    ctr_t n;
    logic [15:0] dec;
    n = c;
    tcp = 1'b0;
    dec = c.cnt - 16'h0001;
    if (g && !c.gate_d) begin
      n.trig = 1'b1;
    end
    if (ce) begin
      n.gate_d = g;
      case (c.mode)
        M_TC_PULSE, M_SW_STROBE: begin
          if (c.pend) begin
            n.cnt = load_val(c.init); // Load on next clock [RULE_04] [RULE_06] [RULE_14]
            n.pend = 1'b0;
            n.run = 1'b1;
          end else if (c.run && g) begin // Gate halts counting [RULE_06]
            n.cnt = dec;
            if (dec == 16'h0000) begin
              tcp = 1'b1;
              n.run = 1'b0;
              if (c.mode == M_TC_PULSE) begin
                n.out = 1'b1; // High at zero, n+1 clocks [RULE_04] [RULE_05]
              end else begin
                n.out = 1'b0; // One-clock strobe [RULE_14]
              end
            end
          end
          if (c.mode == M_SW_STROBE && !c.out) begin
            n.out = 1'b1;
          end
        end
        M_ONE_SHOT, M_HW_STROBE: begin
          if (!c.out && c.mode == M_HW_STROBE) begin
            n.out = 1'b1;
          end
          if ((c.trig || (g && !c.gate_d)) && c.arm) begin
            n.cnt = load_val(c.init); // Retrigger reloads, count reused [RULE_07] [RULE_08]
            n.trig = 1'b0;
            n.run = 1'b1;
            if (c.mode == M_ONE_SHOT) begin
              n.out = 1'b0; // Low on clock after trigger [RULE_07]
            end
          end else if (c.run) begin // Counts down unless a gate edge retriggers first [RULE_08] [RULE_16]
            n.cnt = dec;
            if (dec == 16'h0000) begin
              tcp = 1'b1;
              n.run = 1'b0;
              n.out = (c.mode == M_ONE_SHOT) ? 1'b1 : 1'b0; // [RULE_07] [RULE_15]
            end
          end
        end
        M_RATE_GEN, M_SQUARE: begin
          if (!g) begin
            n.out = 1'b1; // Low gate forces high [RULE_10] [RULE_13]
            n.sq_low = 1'b0;
            if (c.arm) begin
              n.run = 1'b0; // Gate restarts from initial count
            end
          end else if (c.arm && !c.run) begin
            n.cnt = load_val(c.init); // Trigger loads, counts next clock [RULE_09]
            n.run = 1'b1;
            n.out = 1'b1;
          end else if (c.run && c.mode == M_RATE_GEN) begin
            n.cnt = dec;
            n.out = 1'b1;
            if (c.cnt == 16'h0002) begin
              n.out = 1'b0; // Low one clock at one [RULE_09]
            end else if (c.cnt == 16'h0001) begin
              n.cnt = load_val(c.init); // Reload from latest count [RULE_11]
              tcp = 1'b1;
            end
          end else if (c.run) begin
            // Half-period phases: high (n+1)/2, low n/2, integer halves [RULE_12]
            n.cnt = dec;
            if (!c.sq_low && (dec == {1'b0, c.init[15:1]} ||
                (c.init == 16'h0000 && dec == 16'h8000))) begin
              n.sq_low = 1'b1;
              n.out = 1'b0;
            end
            if (dec == 16'h0000 || c.cnt == 16'h0000 && c.init == 16'h0001) begin
              n.cnt = load_val(c.init);
              n.sq_low = 1'b0;
              n.out = 1'b1;
              tcp = 1'b1;
            end
          end
        end
        default: begin
          n.run = 1'b0;
        end
      endcase
    end
    return n;
  endfunction

  assign pace_sel = st_ff.ctrl[CTRL_PACER_SEL_BIT];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign tb_tick = (st_ff.tb_div == TBASE_LAST);
  assign addr_ok = (paddr <= OFS_STAT) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = st_ff.rdata;

  // Synchronised edges and gate levels
  always_comb begin
    // Only general and cascade take pin clocks [RULE_03]
    cen[0] = st_ff.sync2[0] && !st_ff.eclk_d[0];
    // Cascade: 1 MHz when pacing, chained to pacer [RULE_02] [RULE_18]
    if (pace_sel && st_ff.ctrl[CTRL_CASCADE_BIT]) begin
      cen[1] = tb_tick && tc[2];
    end else if (pace_sel) begin
      cen[1] = tb_tick;
    end else begin
      cen[1] = st_ff.sync2[1] && !st_ff.eclk_d[1];
    end
    // Pacer: bus clock/2 after reset, 1 MHz when pacing [RULE_02]
    cen[2] = pace_sel ? tb_tick : st_ff.half_div;
    gate[0] = st_ff.sync2[2]; // General counter stays free [RULE_01]
    // Pacing ignores cascade and pacer gates [RULE_01] [RULE_17]
    gate[1] = pace_sel ? 1'b1 : st_ff.sync2[3];
    gate[2] = pace_sel ? 1'b1 : st_ff.sync2[4];
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;
    tc = 3'b000;
    nxt_st.sync1 = {pacer_counter_gate_pin, cascade_counter_gate_pin,
                    general_counter_gate_pin, cascade_counter_clock_pin,
                    general_counter_clock_pin};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.eclk_d = st_ff.sync2[1:0];
    nxt_st.half_div = !st_ff.half_div;
    nxt_st.tb_div = tb_tick ? 6'h00 : st_ff.tb_div + 6'h01;
    // Pacer steps first so cascade sees its terminal count
    nxt_st.ctr[2] = step(st_ff.ctr[2], cen[2], gate[2], tc[2]);
    nxt_st.ctr[1] = step(st_ff.ctr[1], cen[1], gate[1], tc[1]);
    nxt_st.ctr[0] = step(st_ff.ctr[0], cen[0], gate[0], tc[0]);
    // Conversion start on pacer, or both in cascade [RULE_18] [RULE_19]
    if (st_ff.ctrl[CTRL_CASCADE_BIT]) begin
      nxt_st.conv = pace_sel && tc[2] && tc[1];
    end else begin
      nxt_st.conv = pace_sel && tc[2];
    end
    // Register writes
    if (wr_en && addr_ok) begin
      case (paddr)
        OFS_CTRL: nxt_st.ctrl = pwdata[1:0];
        OFS_MODE0, OFS_MODE1, OFS_MODE2: begin
          for (int i = 0; i < 3; i++) begin
            if (paddr == OFS_MODE0 + 12'(4 * i)) begin
              nxt_st.ctr[i].mode = cnt_mode_t'(pwdata[2:0]);
              // New mode halts counting and disarms [RULE_21]
              nxt_st.ctr[i].run = 1'b0;
              nxt_st.ctr[i].arm = 1'b0;
              nxt_st.ctr[i].pend = 1'b0;
              nxt_st.ctr[i].trig = 1'b0;
              nxt_st.ctr[i].sq_low = 1'b0;
              nxt_st.ctr[i].out = (pwdata[2:0] == M_TC_PULSE); // Low in mode 0 [RULE_04]
              nxt_st.ctr[i].out = !nxt_st.ctr[i].out;
            end
          end
        end
        OFS_CNT0, OFS_CNT1, OFS_CNT2: begin
          for (int i = 0; i < 3; i++) begin
            if (paddr == OFS_CNT0 + 12'(4 * i)) begin
              nxt_st.ctr[i].init = pwdata[15:0]; // Sixteen-bit count [RULE_20]
              nxt_st.ctr[i].arm = 1'b1;
              // Only modes 0 and 4 restart on write [RULE_08] [RULE_11] [RULE_16]
              if (st_ff.ctr[i].mode == M_TC_PULSE || st_ff.ctr[i].mode == M_SW_STROBE) begin
                nxt_st.ctr[i].pend = 1'b1;
                nxt_st.ctr[i].run = 1'b0;
                if (st_ff.ctr[i].mode == M_TC_PULSE) begin
                  nxt_st.ctr[i].out = 1'b0;
                end
              end
            end
          end
        end
        default: ;
      endcase
    end
    // Read data captured in setup phase, held until the next read setup
    if (rd_en) begin
      case (paddr)
        OFS_CTRL: nxt_st.rdata = {30'h0, st_ff.ctrl};
        OFS_MODE0: nxt_st.rdata = {29'h0, st_ff.ctr[0].mode};
        OFS_MODE1: nxt_st.rdata = {29'h0, st_ff.ctr[1].mode};
        OFS_MODE2: nxt_st.rdata = {29'h0, st_ff.ctr[2].mode};
        OFS_CNT0: nxt_st.rdata = {16'h0, st_ff.ctr[0].cnt};
        OFS_CNT1: nxt_st.rdata = {16'h0, st_ff.ctr[1].cnt};
        OFS_CNT2: nxt_st.rdata = {16'h0, st_ff.ctr[2].cnt};
        OFS_STAT: nxt_st.rdata = {26'h0, st_ff.ctr[2].run, st_ff.ctr[1].run,
                                  st_ff.ctr[0].run, st_ff.ctr[2].out,
                                  st_ff.ctr[1].out, st_ff.ctr[0].out};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      for (int i = 0; i < 3; i++) begin
        st_ff.ctr[i].out <= 1'b0;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign general_counter_output_pin = st_ff.ctr[0].out;
  assign cascade_counter_output_pin = st_ff.ctr[1].out;
  assign pacer_counter_output_pin = st_ff.ctr[2].out;
  assign conv_start = st_ff.conv;

endmodule // triple_counter_timer_block

// ---- verif/tct_props.sv ----
`timescale 1ns/1ps
module tct_props
  import tct_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic general_counter_output_pin, // Out 0
  input wire logic cascade_counter_output_pin, // Out 1
  input wire logic pacer_counter_output_pin, // Out 2
  input wire logic conv_start // Start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic bad;
  logic sel_ff;
  // Access phase and unmapped decode
  assign acc = psel && penable;
  assign bad = (paddr > OFS_STAT) || (paddr[1:0] != 2'h0);
  // Tracks the internal pacer select
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= 1'h0;
    end else if (acc && pwrite && paddr == OFS_CTRL) begin
      sel_ff <= pwdata[CTRL_PACER_SEL_BIT];
    end
  end
  AST_READY: assert property (pready) else $error("pready low");
  AST_ERR_PHASE: assert property (pslverr |-> acc) else $error("pslverr outside access");
  AST_ERR_MAP: assert property (acc && bad |-> pslverr) else $error("no pslverr");
  AST_RD_ZERO: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CONV_PULSE: assert property (conv_start |=> !conv_start)
    else $error("conv_start too long");
  AST_CONV_SEL: assert property (conv_start |-> sel_ff || $past(sel_ff, 4))
    else $error("conv_start without pacer");
  AST_TC_LOW: assert property (acc && pwrite && paddr == OFS_MODE0 && pwdata[2:0] == 3'h0
    |-> ##4 !general_counter_output_pin) else $error("mode 0 output not low");
  AST_ONESHOT_HIGH: assert property (acc && pwrite && paddr == OFS_MODE1
    && pwdata[2:0] == 3'h1 |-> ##4 cascade_counter_output_pin) else $error("one-shot not high");
  // Main scenarios
  cover property (conv_start);
  cover property (pslverr);
  cover property ($fell(pacer_counter_output_pin));
endmodule // tct_props
bind triple_counter_timer_block tct_props i_props (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
  .general_counter_output_pin(general_counter_output_pin),
  .cascade_counter_output_pin(cascade_counter_output_pin),
  .pacer_counter_output_pin(pacer_counter_output_pin));

// ---- verif/counter_pins.sv ----
`timescale 1ns/1ps
module counter_pins (
  input wire logic core_clk, // Clock
  output logic [1:0] ext_clk, // Pin clocks
  output logic [2:0] gate // Gate pins
);
  // Clocks idle low, gates idle high as if pulled up
  initial begin
    ext_clk = 2'h0;
    gate = 3'h7;
  end
  // One counter clock, 3 cycles high and 5 low
  task automatic pulse(input int idx);
    @(posedge core_clk);
    ext_clk[idx] <= 1'h1;
    repeat (3) @(posedge core_clk);
    ext_clk[idx] <= 1'h0;
    repeat (5) @(posedge core_clk);
  endtask
  // Gate change on gate pin idx, then a 4-cycle wait
  task automatic set_gate(input int idx, input logic v);
    @(posedge core_clk);
    gate[idx] <= v;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // counter_pins

// ---- verif/triple_counter_timer_block_test.sv ----
`timescale 1ns/1ps
module triple_counter_timer_block_test
  import tct_pkg::*;
;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, conv_start, ev, use_conv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] ext_clk;
  logic [2:0] gate, outs;
  int num_errors, tests_run, p;
  counter_pins i_pins (.core_clk(core_clk), .ext_clk(ext_clk), .gate(gate));
  triple_counter_timer_block i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .general_counter_clock_pin(ext_clk[0]),
    .cascade_counter_clock_pin(ext_clk[1]), .general_counter_gate_pin(gate[0]),
    .cascade_counter_gate_pin(gate[1]), .pacer_counter_gate_pin(gate[2]),
    .general_counter_output_pin(outs[0]), .cascade_counter_output_pin(outs[1]),
    .pacer_counter_output_pin(outs[2]), .conv_start(conv_start));
  // Event whose period is measured
  assign ev = use_conv ? conv_start : !outs[2];
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int k;
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    check("prdata", exp, r);
    check("pslverr", {31'h0, exp_e}, {31'h0, e});
  endtask
  // Cycles between rising edges of ev, last of three
  task measure(output int n);
    logic pv;
    for (int r = 0; r < 3; r++) begin
      n = 0;
      do begin
        pv = ev;
        @(posedge core_clk);
        n++;
      end while (!(ev === 1'h1 && pv === 1'h0) && n < 2000);
    end
  endtask
  task results;
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    results();
  end
  initial begin
    {rst_n, psel, penable, pwrite, use_conv} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(OFS_CTRL, 32'h0, 1'h0);
    rd(12'h020, 32'h0, 1'h1);
    rd(12'h006, 32'h0, 1'h1);
    // Terminal count pulse, count 3
    wr(OFS_MODE0, 32'h0);
    wr(OFS_CNT0, 32'h3);
    for (int i = 1; i <= 4; i++) begin
      i_pins.pulse(0);
      check("general_counter_output_pin", 32'(i == 4), {31'h0, outs[0]});
    end
    // Low gate halts counting after the load
    i_pins.set_gate(0, 1'h0);
    wr(OFS_MODE0, 32'h0);
    wr(OFS_CNT0, 32'h2);
    repeat (3) i_pins.pulse(0);
    check("general_counter_output_pin", 32'h0, {31'h0, outs[0]});
    i_pins.set_gate(0, 1'h1);
    i_pins.pulse(0);
    check("general_counter_output_pin", 32'h0, {31'h0, outs[0]});
    i_pins.pulse(0);
    check("general_counter_output_pin", 32'h1, {31'h0, outs[0]});
    // Software strobe on the cascade counter, count 2
    wr(OFS_MODE1, 32'h4);
    wr(OFS_CNT1, 32'h2);
    for (int i = 1; i <= 4; i++) begin
      i_pins.pulse(1);
      check("cascade_counter_output_pin", 32'(i != 3), {31'h0, outs[1]});
    end
    wr(OFS_MODE1, 32'h1);
    repeat (6) @(posedge core_clk);
    check("cascade_counter_output_pin", 32'h1, {31'h0, outs[1]});
    // Pacer rate generator, count 4, bus clock/2 then time base
    wr(OFS_MODE2, 32'h2);
    wr(OFS_CNT2, 32'h4);
    measure(p);
    check("pacer_period", 32'h8, 32'(p));
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1, 1'h0);
    measure(p);
    check("pacer_period", 32'(4 * TBASE_DIV), 32'(p));
    use_conv = 1'h1;
    measure(p);
    check("conv_period", 32'(4 * TBASE_DIV), 32'(p));
    results();
  end
endmodule // triple_counter_timer_block_test
